// >>> include/otpg_pkg.sv
`default_nettype none
package otpg_pkg;
  // register offsets
  localparam logic [12:0] OTPG_ADDR_PWR   = 13'h008;
  localparam logic [12:0] OTPG_ADDR_CTRL  = 13'h00d;
  localparam logic [12:0] OTPG_ADDR_OMODE = 13'h014;
  localparam logic [12:0] OTPG_ADDR_U1L   = 13'h019;
  localparam logic [12:0] OTPG_ADDR_U1H   = 13'h01a;
  localparam logic [12:0] OTPG_ADDR_U2L   = 13'h01b;
  localparam logic [12:0] OTPG_ADDR_U2H   = 13'h01c;
  // values after reset
  localparam logic [7:0]  OTPG_CTRL_RST   = 8'h00;
  localparam logic [7:0]  OTPG_OMODE_RST  = 8'h40;
  localparam logic [7:0]  OTPG_PWR_RST    = 8'h00;
  localparam logic [7:0]  OTPG_USER_RST   = 8'h00;
  // field positions
  localparam int          OTPG_PN_LONG_RST_BIT  = 4;
  localparam int          OTPG_PN_SHORT_RST_BIT = 5;
  localparam int          OTPG_OFFBIN_BIT       = 0;
  localparam int          OTPG_LEN_LSB          = 4;
  localparam int          OTPG_PWR_DOWN_BIT     = 0;
  // serial port framing and strap timing, in cycles
  localparam logic [3:0]  OTPG_INSTR_LAST       = 4'hf;
  localparam logic [3:0]  OTPG_DATA_LAST        = 4'h7;
  localparam logic [2:0]  OTPG_STRAP_SETTLE_CYC = 3'h6;
  // output word length
  localparam logic [2:0]  OTPG_LEN_MAX_CODE = 3'h4;
  localparam logic [4:0]  OTPG_LEN_MIN      = 5'h0c;
  localparam logic [4:0]  OTPG_LEN_FULL     = 5'h10;
  // fixed words, 16-bit and 12-bit forms, then the PN9 and PN23 seeds
  localparam logic [15:0] OTPG_W16_MID   = 16'h8000;
  localparam logic [11:0] OTPG_W12_MID   = 12'h800;
  localparam logic [15:0] OTPG_W16_ONES  = 16'hfffc;
  localparam logic [11:0] OTPG_W12_ONES  = 12'hfff;
  localparam logic [15:0] OTPG_W16_ZERO  = 16'h0000;
  localparam logic [11:0] OTPG_W12_ZERO  = 12'h000;
  localparam logic [15:0] OTPG_W16_CHK_A = 16'haaa8;
  localparam logic [11:0] OTPG_W12_CHK_A = 12'haaa;
  localparam logic [15:0] OTPG_W16_CHK_B = 16'h5554;
  localparam logic [11:0] OTPG_W12_CHK_B = 12'h555;
  localparam logic [15:0] OTPG_W16_SYNC  = 16'h01fc;
  localparam logic [11:0] OTPG_W12_SYNC  = 12'h03f;
  localparam logic [15:0] OTPG_W16_MIXED = 16'ha19c;
  localparam logic [11:0] OTPG_W12_MIXED = 12'ha33;
  localparam logic [8:0]  OTPG_PN9_SEED  = 9'h1ff;
  localparam logic [22:0] OTPG_PN23_SEED = 23'h7fffff;

  typedef enum logic [3:0] {
    OTPG_MODE_OFF     = 4'b0000, OTPG_MODE_MID      = 4'b0001, OTPG_MODE_FS_POS = 4'b0010,
    OTPG_MODE_FS_NEG  = 4'b0011, OTPG_MODE_CHECKER  = 4'b0100, OTPG_MODE_PN_LONG = 4'b0101,
    OTPG_MODE_PN_SHORT = 4'b0110, OTPG_MODE_WORD_TGL = 4'b0111, OTPG_MODE_USER  = 4'b1000,
    OTPG_MODE_BIT_TGL = 4'b1001, OTPG_MODE_SYNC     = 4'b1010, OTPG_MODE_ONE_BIT = 4'b1011,
    OTPG_MODE_MIXED   = 4'b1100
  } otpg_mode_t;

  typedef enum logic [0:0] {OTPG_SPI_INSTR = 1'b0, OTPG_SPI_DATA = 1'b1} otpg_spi_st_t;

  typedef struct packed {
    logic [3:0]  mode;
    logic        pn_long_rst;
    logic        pn_short_rst;
    logic        offbin;
    logic [2:0]  len_code;
    logic        powerdown;
    logic [15:0] user1;
    logic [15:0] user2;
  } otpg_cfg_t;

  typedef struct packed {
    logic [15:0] word;
    logic [4:0]  len;
    logic        active;
  } otpg_word_t;
endpackage
`default_nettype wire

// >>> logic/otpg_top.sv
`timescale 1ns/1ps
`default_nettype none
module otpg_top
  import otpg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [13:0] adc_data,
  input  wire logic        spi_sclk,
  input  wire logic        serial_select_low,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  output otpg_word_t       word_q,
  output logic             powerdown,
  output logic             offset_binary
);

  // ---------------- serial port, link clock domain ----------------
  logic         spi_rst_n;
  otpg_spi_st_t st_q, st_d;
  logic [3:0]   cnt_q, cnt_d;
  logic [15:0]  sh_q, sh_d;
  logic         rd_q, rd_d;
  logic [12:0]  addr_q, addr_d;
  logic         wr_en;
  logic [7:0]   ctrl_q, ctrl_d, omode_q, omode_d, pwr_q, pwr_d;
  logic [7:0]   u1l_q, u1l_d, u1h_q, u1h_d, u2l_q, u2l_d, u2h_q, u2h_d;
  logic         tgl_q, tgl_d;
  logic [7:0]   rsh_q, rsh_d;
  logic         sdo_q, sdo_d, oe_q, oe_d;
  logic [7:0]   rd_byte;
  otpg_cfg_t    cfg_src;

  assign spi_rst_n = rst_n & ~serial_select_low;

  function automatic logic [7:0] reg_read(input logic [12:0] a);
    case (a)
      OTPG_ADDR_PWR:   reg_read = pwr_q;
      OTPG_ADDR_CTRL:  reg_read = ctrl_q;
      OTPG_ADDR_OMODE: reg_read = omode_q;
      OTPG_ADDR_U1L:   reg_read = u1l_q;
      OTPG_ADDR_U1H:   reg_read = u1h_q;
      OTPG_ADDR_U2L:   reg_read = u2l_q;
      OTPG_ADDR_U2H:   reg_read = u2h_q;
      default:         reg_read = 8'h00;
    endcase
  endfunction

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 4'h1;
    sh_d   = {sh_q[14:0], sdio_in};
    rd_d   = rd_q;
    addr_d = addr_q;
    wr_en  = 1'b0;
    case (st_q)
      OTPG_SPI_INSTR: begin
        if (cnt_q == OTPG_INSTR_LAST) begin
          st_d   = OTPG_SPI_DATA;
          cnt_d  = 4'h0;
          rd_d   = sh_d[15];
          addr_d = sh_d[12:0];
        end
      end
      OTPG_SPI_DATA: begin
        if (cnt_q == OTPG_DATA_LAST) begin
          cnt_d  = 4'h0;
          wr_en  = ~rd_q;
          addr_d = addr_q - 13'h001;
        end
      end
      default: st_d = OTPG_SPI_INSTR;
    endcase
  end

  always_ff @(posedge spi_sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      st_q   <= OTPG_SPI_INSTR;
      cnt_q  <= 4'h0;
      sh_q   <= 16'h0000;
      rd_q   <= 1'b0;
      addr_q <= 13'h0000;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
    end
  end

  // register file; toggle tells the sample side a write landed
  always_comb begin
    ctrl_d  = ctrl_q;
    omode_d = omode_q;
    pwr_d   = pwr_q;
    u1l_d   = u1l_q;
    u1h_d   = u1h_q;
    u2l_d   = u2l_q;
    u2h_d   = u2h_q;
    tgl_d   = tgl_q ^ wr_en;
    if (wr_en) begin
      case (addr_q)
        OTPG_ADDR_PWR:   pwr_d   = sh_d[7:0];
        OTPG_ADDR_CTRL:  ctrl_d  = sh_d[7:0];
        OTPG_ADDR_OMODE: omode_d = sh_d[7:0];
        OTPG_ADDR_U1L:   u1l_d   = sh_d[7:0];
        OTPG_ADDR_U1H:   u1h_d   = sh_d[7:0];
        OTPG_ADDR_U2L:   u2l_d   = sh_d[7:0];
        OTPG_ADDR_U2H:   u2h_d   = sh_d[7:0];
        default:         ctrl_d  = ctrl_q;
      endcase
    end
  end

  always_ff @(posedge spi_sclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= OTPG_CTRL_RST;
      omode_q <= OTPG_OMODE_RST;
      pwr_q   <= OTPG_PWR_RST;
      u1l_q   <= OTPG_USER_RST;
      u1h_q   <= OTPG_USER_RST;
      u2l_q   <= OTPG_USER_RST;
      u2h_q   <= OTPG_USER_RST;
      tgl_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      omode_q <= omode_d;
      pwr_q   <= pwr_d;
      u1l_q   <= u1l_d;
      u1h_q   <= u1h_d;
      u2l_q   <= u2l_d;
      u2h_q   <= u2h_d;
      tgl_q   <= tgl_d;
    end
  end

  // readback shifts out on falling edges
  assign rd_byte = reg_read(addr_q);

  always_comb begin
    rsh_d = {rsh_q[6:0], 1'b0};
    sdo_d = rsh_q[7];
    oe_d  = 1'b0;
    if (st_q == OTPG_SPI_DATA && rd_q) begin
      oe_d = 1'b1;
      if (cnt_q == 4'h0) begin
        rsh_d = {rd_byte[6:0], 1'b0};
        sdo_d = rd_byte[7];
      end
    end
  end

  always_ff @(negedge spi_sclk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      rsh_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      rsh_q <= rsh_d;
      sdo_q <= sdo_d;
      oe_q  <= oe_d;
    end
  end

  assign sdio_out = sdo_q;
  assign sdio_oe  = oe_q;

  always_comb begin
    cfg_src.mode         = ctrl_q[3:0];
    cfg_src.pn_long_rst  = ctrl_q[OTPG_PN_LONG_RST_BIT];
    cfg_src.pn_short_rst = ctrl_q[OTPG_PN_SHORT_RST_BIT];
    cfg_src.offbin       = omode_q[OTPG_OFFBIN_BIT];
    cfg_src.len_code     = omode_q[OTPG_LEN_LSB +: 3];
    cfg_src.powerdown    = pwr_q[OTPG_PWR_DOWN_BIT];
    cfg_src.user1        = {u1h_q, u1l_q};
    cfg_src.user2        = {u2h_q, u2l_q};
  end

  // ---------------- sample clock domain ----------------
  // bit 0 select, 1 clock/format pin, 2 data/power-down pin, 3 write toggle
  logic [3:0]  s1_q, s2_q, s3_q, flt_q, flt_d;
  logic        seen_q, seen_d;
  otpg_cfg_t   cfg_q, cfg_d;
  logic [2:0]  settle_q, settle_d;
  logic        done_q, done_d, twos_q, twos_d;
  logic        strap_q, strap_d;
  logic        strap_mode, offbin_eff, pd_eff;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flt
      assign flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      flt_q <= 4'h0;
    end else begin
      s1_q  <= {tgl_q, sdio_in, spi_sclk, serial_select_low};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end

  always_comb begin
    seen_d   = flt_q[3];
    cfg_d    = cfg_q;
    settle_d = settle_q;
    done_d   = done_q;
    twos_d   = twos_q;
    // strap mode left for good once select drops
    strap_d  = strap_q & flt_q[0];
    // settings are quiet by the time the toggle is seen
    if (flt_q[3] != seen_q) begin
      cfg_d = cfg_src;
    end
    if (!done_q) begin
      if (settle_q == OTPG_STRAP_SETTLE_CYC) begin
        done_d  = 1'b1;
        twos_d  = flt_q[1];
        strap_d = flt_q[0];
      end else begin
        settle_d = settle_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seen_q   <= 1'b0;
      cfg_q    <= '0;
      cfg_q.len_code <= OTPG_LEN_MAX_CODE;
      settle_q <= 3'h0;
      done_q   <= 1'b0;
      twos_q   <= 1'b1;
      strap_q  <= 1'b0;
    end else begin
      seen_q   <= seen_d;
      strap_q  <= strap_d;
      cfg_q    <= cfg_d;
      settle_q <= settle_d;
      done_q   <= done_d;
      twos_q   <= twos_d;
    end
  end

  // idle-high select between frames is not strap mode
  assign strap_mode = strap_q;
  assign offbin_eff = strap_mode ? ~twos_q : cfg_q.offbin;
  assign pd_eff     = strap_mode ? flt_q[2] : cfg_q.powerdown;

  // ---------------- pattern generation ----------------
  logic        alt_q, alt_d;
  logic [8:0]  pn9_q, pn9_d;
  logic [22:0] pn23_q, pn23_d;
  logic [22:0] pn9_nx;
  logic [36:0] pn23_nx;
  logic [15:0] w16, base, conv, mask;
  logic [11:0] w12;
  logic        has12, fmtdep, active;
  logic [4:0]  len;
  otpg_word_t  word_d;

  function automatic logic [22:0] pn9_adv(input logic [8:0] s);
    logic [8:0]  t;
    logic [13:0] b;
    t = s;
    b = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      b[13 - i] = t[8];
      t = {t[7:0], t[8] ^ t[4]};
    end
    return {b, t};
  endfunction

  // register bits leave uninverted, i.e. inverted versus standard
  function automatic logic [36:0] pn23_adv(input logic [22:0] s);
    logic [22:0] t;
    logic [13:0] b;
    t = s;
    b = 14'h0000;
    for (int i = 0; i < 14; i++) begin
      b[13 - i] = t[22];
      t = {t[21:0], t[22] ^ t[17]};
    end
    return {b, t};
  endfunction

  function automatic logic [15:0] fmt_conv(input logic [15:0] w, input logic ob);
    return ob ? w : {~w[15], w[14:0]};
  endfunction

  assign pn9_nx  = pn9_adv(pn9_q);
  assign pn23_nx = pn23_adv(pn23_q);

  always_comb begin
    // state moves only on sample clock
    alt_d  = 1'b0;
    pn9_d  = pn9_q;
    pn23_d = pn23_q;
    if (cfg_q.mode != OTPG_MODE_OFF) begin
      alt_d = ~alt_q;
    end
    if (cfg_q.pn_short_rst) begin
      pn9_d = OTPG_PN9_SEED;
    end else if (cfg_q.mode == OTPG_MODE_PN_SHORT) begin
      pn9_d = pn9_nx[8:0];
    end
    if (cfg_q.pn_long_rst) begin
      pn23_d = OTPG_PN23_SEED;
    end else if (cfg_q.mode == OTPG_MODE_PN_LONG) begin
      pn23_d = pn23_nx[22:0];
    end
  end

  always_comb begin
    w16    = {adc_data, 2'b00};
    w12    = OTPG_W12_ZERO;
    has12  = 1'b0;
    fmtdep = 1'b1;
    active = 1'b1;
    case (cfg_q.mode)
      OTPG_MODE_MID:      begin w16 = OTPG_W16_MID;  w12 = OTPG_W12_MID;  has12 = 1'b1; end
      OTPG_MODE_FS_POS:   begin w16 = OTPG_W16_ONES; w12 = OTPG_W12_ONES; has12 = 1'b1; end
      OTPG_MODE_FS_NEG:   begin w16 = OTPG_W16_ZERO; w12 = OTPG_W12_ZERO; has12 = 1'b1; end
      OTPG_MODE_CHECKER: begin
        w16    = alt_q ? OTPG_W16_CHK_B : OTPG_W16_CHK_A;
        w12    = alt_q ? OTPG_W12_CHK_B : OTPG_W12_CHK_A;
        has12  = 1'b1;
        fmtdep = 1'b0;
      end
      OTPG_MODE_PN_LONG:  w16 = {pn23_nx[36:23], 2'b00};
      OTPG_MODE_PN_SHORT: w16 = {pn9_nx[22:9], 2'b00};
      OTPG_MODE_WORD_TGL: begin
        w16    = alt_q ? OTPG_W16_ZERO : OTPG_W16_ONES;
        w12    = alt_q ? OTPG_W12_ZERO : OTPG_W12_ONES;
        has12  = 1'b1;
        fmtdep = 1'b0;
      end
      OTPG_MODE_USER: begin
        w16    = alt_q ? cfg_q.user2 : cfg_q.user1;
        fmtdep = 1'b0;
      end
      OTPG_MODE_BIT_TGL:  begin w16 = OTPG_W16_CHK_A; w12 = OTPG_W12_CHK_A; has12 = 1'b1; fmtdep = 1'b0; end
      OTPG_MODE_SYNC:     begin w16 = OTPG_W16_SYNC;  w12 = OTPG_W12_SYNC;  has12 = 1'b1; fmtdep = 1'b0; end
      OTPG_MODE_ONE_BIT:  begin w16 = OTPG_W16_MID;   w12 = OTPG_W12_MID;   has12 = 1'b1; fmtdep = 1'b0; end
      OTPG_MODE_MIXED:    begin w16 = OTPG_W16_MIXED; w12 = OTPG_W12_MIXED; has12 = 1'b1; fmtdep = 1'b0; end
      default:            active = 1'b0;
    endcase
  end

  always_comb begin
    len  = (cfg_q.len_code > OTPG_LEN_MAX_CODE) ? OTPG_LEN_FULL : OTPG_LEN_MIN + {2'b00, cfg_q.len_code};
    mask = 16'hffff << (OTPG_LEN_FULL - len);
    base = (has12 && len == OTPG_LEN_MIN) ? {w12, 4'h0} : w16;
    conv = fmtdep ? fmt_conv(base, offbin_eff) : base;
    word_d.word   = conv & mask;
    word_d.len    = len;
    word_d.active = active;
    if (pd_eff) begin
      word_d.word   = 16'h0000;
      word_d.active = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alt_q         <= 1'b0;
      pn9_q         <= OTPG_PN9_SEED;
      pn23_q        <= OTPG_PN23_SEED;
      word_q        <= '0;
      powerdown     <= 1'b0;
      offset_binary <= 1'b0;
    end else begin
      alt_q         <= alt_d;
      pn9_q         <= pn9_d;
      pn23_q        <= pn23_d;
      word_q        <= word_d;
      powerdown     <= pd_eff;
      offset_binary <= offbin_eff;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_run(logic [3:0] m);
    cfg_q.mode == m && !pd_eff && !offbin_eff && len == OTPG_LEN_FULL;
  endsequence

  property p_off_passes;
    s_run(OTPG_MODE_OFF) |=> word_q.word == {~$past(adc_data[13]), $past(adc_data[12:0]), 2'b00} && !word_q.active;
  endproperty
  a_off_passes: assert property (p_off_passes) else $error("data path wrong when off");

  property p_checker;
    (s_run(OTPG_MODE_CHECKER)) [*2] |=> (word_q.word == OTPG_W16_CHK_A || word_q.word == OTPG_W16_CHK_B)
      && word_q.word != $past(word_q.word);
  endproperty
  a_checker: assert property (p_checker) else $error("checkerboard not alternating");

  sequence s_pn9_restart;
    cfg_q.pn_short_rst ##1 (!cfg_q.pn_short_rst and s_run(OTPG_MODE_PN_SHORT));
  endsequence

  property p_pn9_first;
    s_pn9_restart |=> word_q.word == 16'h7f80;
  endproperty
  a_pn9_first: assert property (p_pn9_first) else $error("short PN first word wrong");

  property p_pn9_second;
    s_pn9_restart ##1 (!cfg_q.pn_short_rst and s_run(OTPG_MODE_PN_SHORT)) |=> word_q.word == 16'h77c4;
  endproperty
  a_pn9_second: assert property (p_pn9_second) else $error("short PN second word wrong");

  property p_pn23_first;
    cfg_q.pn_long_rst ##1 (!cfg_q.pn_long_rst and s_run(OTPG_MODE_PN_LONG)) |=> word_q.word == 16'h7ffc;
  endproperty
  a_pn23_first: assert property (p_pn23_first) else $error("long PN first word wrong");

  property p_mid_fmt;
    (cfg_q.mode == OTPG_MODE_MID && !pd_eff && len == OTPG_LEN_FULL)
      |=> word_q.word == ($past(offbin_eff) ? OTPG_W16_MID : 16'h0000);
  endproperty
  a_mid_fmt: assert property (p_mid_fmt) else $error("midscale format wrong");

  property p_sync12;
    (cfg_q.mode == OTPG_MODE_SYNC && !pd_eff && len == OTPG_LEN_MIN) |=> word_q.word == 16'h03f0;
  endproperty
  a_sync12: assert property (p_sync12) else $error("12-bit sync word wrong");

  property p_user;
    (cfg_q.mode == OTPG_MODE_USER && !pd_eff && len == OTPG_LEN_FULL)
      |=> word_q.word == ($past(alt_q) ? $past(cfg_q.user2) : $past(cfg_q.user1));
  endproperty
  a_user: assert property (p_user) else $error("user word wrong");

  property p_strap_pd;
    (strap_q && flt_q[2]) |=> powerdown && word_q.word == 16'h0000 && !word_q.active;
  endproperty
  a_strap_pd: assert property (p_strap_pd) else $error("strap power-down ignored");

  property p_unused;
    (cfg_q.mode > OTPG_MODE_MIXED) |=> !word_q.active;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code activated pattern");

endmodule // otpg_top
`default_nettype wire

// >>> test/otpg_rx.sv
`timescale 1ns/1ps
`default_nettype none
module otpg_rx
  import otpg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire otpg_word_t  word_q,
  output logic [15:0]      last_q,
  output logic [15:0]      prev_q
);
  logic [15:0] last_d;
  // receiver keeps only the bits of the active length
  always_comb begin
    last_d = word_q.word & ~(16'hffff >> word_q.len);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 16'h0000;
      prev_q <= 16'h0000;
    end else begin
      last_q <= last_d;
      prev_q <= last_q;
    end
  end
endmodule // otpg_rx
`default_nettype wire

// >>> test/output_test_pattern_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module output_test_pattern_generator_test
  import otpg_pkg::*;
;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        spi_sclk = 1'b0;
  logic        serial_select_low = 1'b1;
  logic        sdio_in = 1'b1;
  logic [13:0] adc_data = 14'h1234;
  otpg_word_t  word_q;
  logic        sdio_out;
  logic        sdio_oe;
  logic        powerdown;
  logic        offset_binary;
  logic [15:0] rx_last;
  logic [15:0] rx_prev;
  logic [7:0]  rv;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [3:0]  fc [7] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'hc};
  logic [15:0] fw [7] = '{16'h0000, 16'h7ffc, 16'h8000, 16'haaa8, 16'h01fc, 16'h8000, 16'ha19c};
  logic [3:0]  ac [3] = '{4'h4, 4'h7, 4'h8};
  logic [15:0] aw [3] = '{16'haaa8, 16'hfffc, 16'hc35a};
  logic [15:0] bw [3] = '{16'h5554, 16'h0000, 16'h0f96};

  always #25 clock = ~clock;

  otpg_top dut (.clock(clock), .rst_n(rst_n), .adc_data(adc_data), .spi_sclk(spi_sclk),
    .serial_select_low(serial_select_low), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .word_q(word_q), .powerdown(powerdown), .offset_binary(offset_binary));
  otpg_rx rx (.clock(clock), .rst_n(rst_n), .word_q(word_q), .last_q(rx_last), .prev_q(rx_prev));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one frame: instruction then one byte, sclk runs only inside it
  task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] r);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    @(posedge clock) serial_select_low <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #7 sdio_in = (rd && i < 8) ? i[0] : f[i];
      #25 r[i % 8] = sdio_out;
      if (i == 7) check(sdio_oe, rd);
      spi_sclk = 1'b1;
      #32 spi_sclk = 1'b0;
    end
    #20 serial_select_low = 1'b1;
  endtask

  task automatic set(input logic [12:0] a, input logic [7:0] d);
    spi(1'b0, a, d, rv);
    repeat (10) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic pn(input logic [7:0] hold, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    int n;
    set(OTPG_ADDR_CTRL, hold);
    check(word_q.word, w0);
    spi(1'b0, OTPG_ADDR_CTRL, {4'h0, hold[3:0]}, rv);
    n = 0;
    while (word_q.word === w0 && n < 30) begin
      @(negedge clock);
      n++;
    end
    check(word_q.word, w1);
    @(negedge clock);
    check(word_q.word, w2);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    // strap start: format pin low, power-down pin high
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    @(negedge clock);
    check({offset_binary, powerdown}, 2'b11);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock) spi_sclk <= ~spi_sclk;
    end
    @(negedge clock);
    check({word_q.active, offset_binary, powerdown}, 3'b011);
    @(posedge clock) rst_n <= 1'b0;
    spi_sclk <= 1'b1;
    sdio_in <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (10) @(posedge clock);
    spi_sclk <= 1'b0;
    @(negedge clock);
    check({offset_binary, powerdown}, 2'b00);
    check(word_q, {~adc_data[13], adc_data[12:0], 2'b00, 5'h10, 1'b0});
    spi(1'b1, OTPG_ADDR_CTRL, 8'h00, rv);
    check(rv, OTPG_CTRL_RST);
    spi(1'b1, OTPG_ADDR_OMODE, 8'h00, rv);
    check(rv, OTPG_OMODE_RST);
    spi(1'b0, 13'h0ff, 8'h5a, rv);
    spi(1'b1, 13'h0ff, 8'h00, rv);
    check(rv, 8'h00);
    for (int i = 0; i < 7; i++) begin
      set(OTPG_ADDR_CTRL, {4'h0, fc[i]});
      check({word_q.word, word_q.active}, {fw[i], 1'b1});
      @(posedge clock) adc_data <= ~adc_data;
      repeat (2) @(negedge clock);
      check(rx_last, fw[i]);
    end
    set(OTPG_ADDR_U1L, 8'h5a);
    set(OTPG_ADDR_U1H, 8'hc3);
    set(OTPG_ADDR_U2L, 8'h96);
    set(OTPG_ADDR_U2H, 8'h0f);
    spi(1'b1, OTPG_ADDR_U1H, 8'h00, rv);
    check(rv, 8'hc3);
    for (int i = 0; i < 3; i++) begin
      set(OTPG_ADDR_CTRL, {4'h0, ac[i]});
      for (int k = 0; k < 2; k++) begin
        @(negedge clock);
        check({rx_prev, rx_last} === {aw[i], bw[i]} || {rx_prev, rx_last} === {bw[i], aw[i]}, 1'b1);
      end
    end
    for (int c = 13; c < 16; c++) begin
      set(OTPG_ADDR_CTRL, 8'(c));
      check(word_q, {~adc_data[13], adc_data[12:0], 2'b00, 5'h10, 1'b0});
    end
    pn(8'h26, 16'h7f80, 16'h77c4, 16'hf320);
    pn(8'h15, 16'h7ffc, 16'h7f80, 16'h8004);
    set(OTPG_ADDR_OMODE, 8'h00);
    set(OTPG_ADDR_CTRL, 8'h0a);
    check({word_q.len, rx_last}, {5'h0c, 16'h03f0});
    set(OTPG_ADDR_OMODE, 8'h41);
    set(OTPG_ADDR_CTRL, 8'h02);
    check({offset_binary, word_q.word}, {1'b1, 16'hfffc});
    set(OTPG_ADDR_CTRL, 8'h09);
    check(word_q.word, 16'haaa8);
    set(OTPG_ADDR_PWR, 8'h01);
    check({powerdown, word_q}, {1'b1, 16'h0000, OTPG_LEN_FULL, 1'b0});
    tally_and_finish();
  end
endmodule // output_test_pattern_generator_test
`default_nettype wire
